/* File: src/sasr_host.sv */
`default_nettype none

module sasr_host #(
  parameter int CHAIN_N = 1,
  parameter int HALF    = sasr_pkg::SCLK_HALF
) (
  input  wire logic                      clk,
  input  wire logic                      reset,
  sasr_link_if.host                      link,
  input  wire logic                      start,
  input  wire sasr_pkg::sasr_mode_t      mode_sel,
  output logic                           busy,
  output logic [sasr_pkg::RES_W-1:0]     word_out,
  output logic                           word_valid
);

  localparam int TOT   = sasr_pkg::RES_W * CHAIN_N;
  localparam int BIT_W = $clog2(TOT + 1);

  typedef enum logic [2:0] {
    IDLE, SETUP, CONV, SEL, HI, LO, RELEASE, PARK
  } sasr_hstate_t;

  sasr_hstate_t                  state_r;
  sasr_pkg::sasr_mode_t          mode_r;
  logic [sasr_pkg::TMR_W-1:0]    tmr_r;
  logic [BIT_W-1:0]              bit_r;
  logic [sasr_pkg::RES_W-1:0]    shift_r;
  logic [sasr_pkg::RES_W-1:0]    word_r;
  logic                          valid_r;
  logic                          busy_r;
  logic                          conversion_start_pin_r;
  logic                          din_r;
  logic                          sclk_r;
  logic                          dout_m_r;
  logic                          dout_s_r;
  logic [sasr_pkg::RES_W-1:0]    shift_nxt;

  assign shift_nxt = {shift_r[sasr_pkg::RES_W-2:0], dout_s_r};

  // The returned data line is asynchronous to this clock, so two flops first.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dout_m_r <= 1'b1;
      dout_s_r <= 1'b1;
    end else begin
      dout_m_r <= link.dout;
      dout_s_r <= dout_m_r;
    end
  end

  // One transfer: set select level, start, wait out the conversion, then read.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r  <= IDLE;
      mode_r   <= sasr_pkg::SASR_3WIRE;
      tmr_r    <= '0;
      bit_r    <= '0;
      shift_r  <= '0;
      word_r   <= '0;
      valid_r  <= 1'b0;
      busy_r   <= 1'b0;
      conversion_start_pin_r <= 1'b0;
      din_r    <= 1'b1;
      sclk_r   <= 1'b0;
    end else begin
      valid_r <= 1'b0;
      unique case (state_r)
        IDLE: begin
          busy_r <= 1'b0;
          if (start) begin
            mode_r  <= mode_sel;
            busy_r  <= 1'b1;
            din_r   <= (mode_sel != sasr_pkg::SASR_CHAIN); // [R22]
            tmr_r   <= sasr_pkg::TMR_W'(sasr_pkg::SETUP_CYC);
            state_r <= SETUP;
          end
        end
        SETUP: begin
          // Serial clock is still low here when the start pin rises. [R18]
          if (tmr_r == '0) begin
            conversion_start_pin_r <= 1'b1;
            tmr_r    <= sasr_pkg::TMR_W'(sasr_pkg::WAIT_CYC);
            state_r  <= CONV;
          end else begin
            tmr_r <= tmr_r - 1'b1;
          end
        end
        CONV: begin
          // In both select modes both pins stay high past the longest conversion; chain mode holds select low. [R4] [R7] [R12]
          if (tmr_r == '0) begin
            if (mode_r == sasr_pkg::SASR_3WIRE) begin
              conversion_start_pin_r <= 1'b0;
            end
            if (mode_r == sasr_pkg::SASR_4WIRE) begin
              din_r <= 1'b0; // Start stays high, so never both low. [R15]
            end
            tmr_r   <= sasr_pkg::TMR_W'(sasr_pkg::SEL_CYC);
            bit_r   <= '0;
            state_r <= SEL;
          end else begin
            tmr_r <= tmr_r - 1'b1;
          end
        end
        SEL: begin
          if (tmr_r == '0) begin
            sclk_r  <= 1'b1;
            tmr_r   <= sasr_pkg::TMR_W'(HALF - 1);
            state_r <= HI;
          end else begin
            tmr_r <= tmr_r - 1'b1;
          end
        end
        HI: begin
          // Bit captured just before the falling edge that retires it. [R10]
          if (tmr_r == '0) begin
            shift_r <= shift_nxt;
            sclk_r  <= 1'b0;
            bit_r   <= bit_r + 1'b1;
            tmr_r   <= sasr_pkg::TMR_W'(HALF - 1);
            if (bit_r[3:0] == 4'hf) begin
              word_r  <= shift_nxt;
              valid_r <= 1'b1;
            end
            state_r <= (bit_r == BIT_W'(TOT - 1)) ? RELEASE : LO; // [R21]
          end else begin
            tmr_r <= tmr_r - 1'b1;
          end
        end
        LO: begin
          if (tmr_r == '0) begin
            sclk_r  <= 1'b1;
            tmr_r   <= sasr_pkg::TMR_W'(HALF - 1);
            state_r <= HI;
          end else begin
            tmr_r <= tmr_r - 1'b1;
          end
        end
        RELEASE: begin
          // Start is held until all chained bits are in. [R11] [R17]
          if (mode_r == sasr_pkg::SASR_4WIRE) begin
            din_r <= 1'b1; // Output floats before any other select. [R14]
          end
          if (mode_r == sasr_pkg::SASR_CHAIN) begin
            conversion_start_pin_r <= 1'b0;
          end
          tmr_r   <= sasr_pkg::TMR_W'(sasr_pkg::GAP_CYC);
          state_r <= PARK;
        end
        PARK: begin
          if (tmr_r == '0) begin
            conversion_start_pin_r <= 1'b0;
            state_r  <= IDLE;
          end else begin
            tmr_r <= tmr_r - 1'b1;
          end
        end
      endcase
    end
  end

  assign link.conversion_start_pin = conversion_start_pin_r;
  assign link.din    = din_r;
  assign link.sclk   = sclk_r;
  assign busy        = busy_r;
  assign word_out    = word_r;
  assign word_valid  = valid_r;

endmodule : sasr_host

`default_nettype wire

/* File: src/sasr_pkg.sv */
// Contract
// (R1) Select high at start edge picks select mode.
// (R2) Select low or tied to start picks chain.
// (R3) Internal clock times conversion within min and max.
// (R4) Read only after conversion, during acquisition.
// (R5) Result is two's complement of differential input.
// (R6) 3-wire start edge floats output, starts conversion.
// (R7) 3-wire host restores start high before min time.
// (R8) 3-wire start fall drives MSB, clock shifts.
// (R9) 3-wire output floats at 16th fall or start.
// (R10) Bits hold across both serial clock edges.
// (R11) 4-wire host holds start high through readout.
// (R12) 4-wire select back high before min time.
// (R13) 4-wire select fall drives MSB, floats at 16.
// (R14) Next select only after previous output floats.
// (R15) Host never lowers start and select together.
// (R16) Output driven low while both pins low.
// (R17) Chain host holds start high through readout.
// (R18) Serial clock low at chain start edge.
// (R19) Chain end loads 16-bit register, drives MSB.
// (R20) Chain falling edge shifts chain input through.
// (R21) Host issues 16 times N falling edges.
// (R22) First chain input low, outputs feed next inputs.
`default_nettype none

package sasr_pkg;

  // Result word width and the clock period of both ends.
  localparam int RES_W   = 16;
  localparam int CLK_NS  = 100;

  // Conversion time bounds in nanoseconds.
  localparam int TCONV_MIN_NS = 500;
  localparam int TCONV_MAX_NS = 900;

  // A least time rounds up, a longest time rounds down.
  localparam int TCONV_MIN_CYC = (TCONV_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int TCONV_MAX_CYC = TCONV_MAX_NS / CLK_NS;
  localparam int CONV_CNT_W    = $clog2(TCONV_MAX_CYC + 1);

  // Host margins covering the device's two-flop pin synchronisers.
  localparam int SETUP_CYC = 3;
  localparam int SEL_CYC   = 4;
  localparam int GAP_CYC   = 3;
  localparam int WAIT_CYC  = TCONV_MAX_CYC + 4;
  localparam int TMR_W     = 8;

  // Default half period of the serial clock in host cycles.
  localparam int SCLK_HALF = 4;

  // Interface options that the host can run.
  typedef enum logic [1:0] {
    SASR_3WIRE,
    SASR_4WIRE,
    SASR_CHAIN
  } sasr_mode_t;

endpackage : sasr_pkg

`default_nettype wire

/* File: src/sasr_link_if.sv */
`default_nettype none

// Serial link between host and converter; the serial clock is the link clock.
interface sasr_link_if;
  logic conversion_start_pin;     // Conversion start pin.
  logic din;        // Select or chain input pin.
  logic sclk;       // Serial clock, made by the host.
  logic dout_o;     // Level the device drives on its output.
  logic dout_oe_n;  // Low while the device drives its output.
  logic dout;       // Resolved line level.

  // A weak pull-up holds the line high while the device floats it.
  assign dout = dout_oe_n ? 1'b1 : dout_o;

  modport device (
    input  conversion_start_pin,
    input  din,
    input  sclk,
    output dout_o,
    output dout_oe_n
  );

  modport host (
    output conversion_start_pin,
    output din,
    output sclk,
    input  dout
  );
endinterface : sasr_link_if

`default_nettype wire

/* File: src/sasr_device.sv */
`default_nettype none

// Converter end of the link. The conversion runs on clk, standing in for the
// internal conversion clock; the shift register runs on the serial clock.
module sasr_device #(
  parameter int RES_W   = sasr_pkg::RES_W,
  parameter int MIN_CYC = sasr_pkg::TCONV_MIN_CYC,
  parameter int MAX_CYC = sasr_pkg::TCONV_MAX_CYC
) (
  input  wire logic              clk,
  input  wire logic              reset,
  sasr_link_if.device            link,
  input  wire logic [RES_W-1:0]  sample_in,
  output logic                   conv_busy,
  output logic                   result_ready
);

  localparam int CW   = sasr_pkg::CONV_CNT_W;
  localparam int BITW = $clog2(RES_W + 1);

  // Pin synchronisers on clk.
  logic             conversion_start_pin_m_r;
  logic             conversion_start_pin_s_r;
  logic             conversion_start_pin_d_r;
  logic             din_m_r;
  logic             din_s_r;
  logic             din_d_r;

  // Conversion state on clk.
  logic             busy_r;
  logic [CW-1:0]    cnt_r;
  logic             jit_r;
  logic [RES_W-1:0] smp_r;
  logic [RES_W-1:0] res_r;
  logic             res_tgl_r;
  logic             have_r;
  logic             mode_valid_r;
  logic             mode_cs_r;

  // Shift state on the serial clock.
  logic             seen_r;
  logic [RES_W-1:0] sh_r;
  logic [BITW-1:0]  bits_r;
  logic             done_r;

  // Combinational terms.
  logic             start_rise;
  logic             conv_last;
  logic [CW-1:0]    conv_target;
  logic             pending;
  logic             cs_sel;
  logic             both_low;
  logic             drive;
  logic             dout_val;

  // The start and select pins come from outside: two flops before any use on clk.
  // A third stage keeps the previous level for edge detection.
  // Reset leaves the select stage low, so the line is driven low for the
  // two cycles that a high select pin needs to pass through after reset.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      conversion_start_pin_m_r <= 1'b0;
      conversion_start_pin_s_r <= 1'b0;
      conversion_start_pin_d_r <= 1'b0;
      din_m_r    <= 1'b0;
      din_s_r    <= 1'b0;
      din_d_r    <= 1'b0;
    end else begin
      conversion_start_pin_m_r <= link.conversion_start_pin;
      conversion_start_pin_s_r <= conversion_start_pin_m_r;
      conversion_start_pin_d_r <= conversion_start_pin_s_r;
      din_m_r    <= link.din;
      din_s_r    <= din_m_r;
      din_d_r    <= din_s_r;
    end
  end

  assign start_rise = conversion_start_pin_s_r & ~conversion_start_pin_d_r;

  // Mode is latched at each start edge that begins a conversion. Select mode needs the select pin
  // high before and at the edge; a select pin wired to the start pin was
  // low one cycle earlier, so that wiring falls into chain mode.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_valid_r <= 1'b0;
      mode_cs_r    <= 1'b0;
    end else if (start_rise && !busy_r) begin
      mode_valid_r <= 1'b1;
      mode_cs_r    <= din_s_r & din_d_r; // [R1] [R2]
    end
  end

  // Conversion length alternates between the two bounds, so both the
  // shortest and the longest case appear on the link.
  assign conv_target = jit_r ? CW'(MIN_CYC - 1) : CW'(MAX_CYC - 1); // [R3]
  assign conv_last   = busy_r && (cnt_r == conv_target);

  // A start edge samples the input and begins a conversion; later pin
  // activity is ignored until the conversion ends. [R6]
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busy_r <= 1'b0;
      cnt_r  <= '0;
      jit_r  <= 1'b0;
      smp_r  <= '0;
    end else if (!busy_r) begin
      if (start_rise) begin
        busy_r <= 1'b1;
        cnt_r  <= '0;
        smp_r  <= sample_in; // Input is already a two's complement code. [R5]
      end
    end else if (conv_last) begin
      busy_r <= 1'b0;
      jit_r  <= ~jit_r;
    end else begin
      cnt_r <= cnt_r + 1'b1; // Independent of the serial clock. [R3]
    end
  end

  // The finished word is published with a toggle. It stays unchanged until
  // the next conversion ends, which the host may not start before the read
  // is over, so the serial side may use it without a synchroniser.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      res_r     <= '0;
      res_tgl_r <= 1'b0;
      have_r    <= 1'b0;
    end else if (conv_last) begin
      res_r     <= smp_r;
      res_tgl_r <= ~res_tgl_r;
      have_r    <= 1'b1; // Readable only from here on. [R4]
    end
  end

  // A new word waits until the first serial falling edge takes it over.
  assign pending = res_tgl_r ^ seen_r;

  // Serial side. The first falling edge after a conversion loads the word
  // with its MSB already shifted out; every later edge shifts the chain
  // input in and the next bit out. The bit count ends a select-mode frame
  // at the 16th falling edge.
  // A frame cut short by a select rise keeps its place: a later select
  // resumes at the next bit, not at the MSB, so a host that aborts a read
  // must start a new conversion to see the word from the top.
  // The word and its toggle cross from clk without synchronisers; this is
  // safe only because the host may not clock while a conversion ends.
  always_ff @(negedge link.sclk or posedge reset) begin
    if (reset) begin
      seen_r <= 1'b0;
      sh_r   <= '0;
      bits_r <= '0;
      done_r <= 1'b1;
    end else if (pending) begin
      seen_r <= res_tgl_r;
      sh_r   <= {res_r[RES_W-2:0], link.din}; // [R19] [R20]
      bits_r <= BITW'(1);
      done_r <= 1'b0;
    end else begin
      sh_r <= {sh_r[RES_W-2:0], link.din}; // [R20]
      if (!done_r) begin
        bits_r <= bits_r + 1'b1;
        done_r <= (bits_r == BITW'(RES_W - 1)); // [R9] [R13]
      end
    end
  end

  // In select mode either pin low selects: 3-wire ties the select pin high
  // and 4-wire holds the start pin high, and both never go low together.
  assign cs_sel   = ~(conversion_start_pin_s_r & din_s_r);
  assign both_low = ~conversion_start_pin_s_r & ~din_s_r;

  // Output enable. In select mode the output floats during conversion, is
  // driven after a select fall, and floats again after 16 falling edges or
  // when select rises. Chain mode drives the line all the time.
  // Until the first start edge no mode is known, so the line floats then
  // unless both pins are low.
  always_comb begin
    if (both_low) begin
      drive = 1'b1; // [R16]
    end else if (!mode_valid_r) begin
      drive = 1'b0;
    end else if (mode_cs_r) begin
      drive = cs_sel && have_r && !busy_r && (pending || !done_r); // [R8] [R9] [R13]
    end else begin
      drive = 1'b1; // [R19]
    end
  end

  // Data level. The MSB stands while the word is pending, each later bit
  // from one falling edge to the next, so it is valid on both edges.
  always_comb begin
    if (both_low || busy_r) begin
      dout_val = 1'b0; // [R16]
    end else if (pending) begin
      dout_val = res_r[RES_W-1]; // [R8] [R19]
    end else begin
      dout_val = sh_r[RES_W-1]; // [R10]
    end
  end

  // The pin follows the edges of two domains at once, as the real part
  // does, so it cannot come from a single flop.
  assign link.dout_o    = dout_val;
  assign link.dout_oe_n = ~drive;

  assign conv_busy    = busy_r;
  assign result_ready = have_r;

endmodule : sasr_device

`default_nettype wire

/* File: testbench/sasr_link_sva.sv */
`default_nettype none

// Watches the host-to-converter link; only clk, reset and the interface's signals are seen here.
module sasr_link_sva (
  input wire logic clk,
  input wire logic reset,
  input wire logic conversion_start_pin,
  input wire logic din,
  input wire logic sclk,
  input wire logic dout_o,
  input wire logic dout_oe_n,
  input wire logic dout
);
  timeunit 1ns;
  timeprecision 1ns;

  localparam int MAXC = sasr_pkg::TCONV_MAX_CYC;

  logic       conversion_start_pin_q_r;
  logic       sclk_q_r;
  logic       cs_mode_r;
  logic [4:0] falls_r;
  logic [7:0] since_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Edge history, and the mode latched at each start edge so framing checks know the mode.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      conversion_start_pin_q_r <= 1'b0;
      sclk_q_r   <= 1'b0;
      cs_mode_r  <= 1'b0;
    end else begin
      conversion_start_pin_q_r <= conversion_start_pin;
      sclk_q_r   <= sclk;
      if (conversion_start_pin && !conversion_start_pin_q_r) begin
        cs_mode_r <= din;
      end
    end
  end

  // Counters restart at each start edge; they saturate so a long idle never wraps into a window.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      since_r <= 8'hff;
      falls_r <= 5'h1f;
    end else if (conversion_start_pin && !conversion_start_pin_q_r) begin
      since_r <= 8'h00;
      falls_r <= 5'h00;
    end else begin
      since_r <= (since_r == 8'hff) ? since_r : since_r + 8'h01;
      if (sclk_q_r && !sclk && falls_r != 5'h1f) begin
        falls_r <= falls_r + 5'h01;
      end
    end
  end

  AST_CONV_FLOAT: assert property ($rose(conversion_start_pin) && din |-> ##4 dout_oe_n [*5])
    else $error("output driven during a select-mode conversion");
  AST_CHAIN_DRIVE: assert property ($rose(conversion_start_pin) && !din |-> ##4 !dout_oe_n)
    else $error("output not driven after a chain-mode start");
  AST_BOTH_LOW: assert property ((!conversion_start_pin && !din) [*4] |-> !dout_oe_n && !dout_o && !dout)
    else $error("output not driven low while both pins low");
  AST_MSB_ON_SELECT: assert property (cs_mode_r && falls_r == 5'h00
      && since_r > MAXC && (($fell(conversion_start_pin) && din) || ($fell(din) && conversion_start_pin))
      |-> ##[1:4] !dout_oe_n)
    else $error("output not enabled after select fell");
  AST_FLOAT_AT_16: assert property (cs_mode_r && $fell(sclk) && falls_r == 5'h0f
      |-> ##[0:1] dout_oe_n)
    else $error("output still driven after the sixteenth clock fall");
  AST_STABLE_HIGH: assert property (sclk && !dout_oe_n |-> $stable(dout_o))
    else $error("data changed while the serial clock was high");
  AST_SCLK_LOW_START: assert property ($rose(conversion_start_pin) |-> !sclk)
    else $error("serial clock high at a start edge");
  AST_CHAIN_HOLD: assert property (!cs_mode_r && $fell(sclk) |-> conversion_start_pin)
    else $error("start line low during a chain readout");
  AST_READ_AFTER_CONV: assert property ($fell(sclk) |-> since_r > MAXC)
    else $error("serial clock fell before the conversion could end");
  AST_SEL_WINDOW: assert property (cs_mode_r && since_r > 8'h00 && since_r <= MAXC
      |-> conversion_start_pin && din)
    else $error("select pins low inside the conversion window");
  AST_CS_NOT_BOTH_LOW: assert property (cs_mode_r && falls_r < 5'h10 |-> conversion_start_pin || din)
    else $error("start and select pins low together in select mode");

  COV_CS_START: cover property ($rose(conversion_start_pin) && din);
  COV_4WIRE_SEL: cover property ($fell(din) && conversion_start_pin);
  COV_CHAIN_END: cover property (!cs_mode_r && $fell(sclk) && falls_r == 5'h0f);
endmodule : sasr_link_sva

`default_nettype wire

/* File: testbench/sasr_test.sv */
`default_nettype none

module sasr_test;
  timeunit 1ns;
  timeprecision 1ns;

  logic                 clk = 1'b0;
  logic                 reset = 1'b1;
  logic                 start = 1'b0;
  sasr_pkg::sasr_mode_t mode_sel = sasr_pkg::SASR_3WIRE;
  logic [15:0]          sample = 16'h0000;
  logic [15:0]          sample2 = 16'h5a3c;
  logic [15:0]          word_out;
  logic [15:0]          wire_sh = 16'h0000;
  logic                 busy, word_valid, conv_busy, result_ready, conv_busy2, result_ready2;
  int                   fails = 0, compares = 0, cycles = 0, falls = 0, words = 0;

  sasr_link_if link ();
  sasr_link_if link2 ();

  // Host clock; the link clock is divided from it inside the host.
  always #50 clk = ~clk;

  sasr_host sasr_host_i (.clk(clk), .reset(reset), .link(link.host), .start(start),
    .mode_sel(mode_sel), .busy(busy), .word_out(word_out), .word_valid(word_valid));
  sasr_device sasr_device_i (.clk(clk), .reset(reset), .link(link.device),
    .sample_in(sample), .conv_busy(conv_busy), .result_ready(result_ready));
  // A lone converter driven straight from the bench, for pin sequences the host never makes.
  sasr_device sasr_device_i2 (.clk(clk), .reset(reset), .link(link2.device),
    .sample_in(sample2), .conv_busy(conv_busy2), .result_ready(result_ready2));
  sasr_link_sva sasr_link_sva_i (.clk(clk), .reset(reset), .conversion_start_pin(link.conversion_start_pin),
    .din(link.din), .sclk(link.sclk), .dout_o(link.dout_o), .dout_oe_n(link.dout_oe_n),
    .dout(link.dout));

  // Wire-side monitors: bits are taken on the rising clock edge, the host takes them falling.
  always @(posedge link.sclk) wire_sh <= {wire_sh[14:0], link.dout};
  always @(negedge link.sclk) falls++;
  always @(posedge clk) if (word_valid === 1'b1) words++;

  // Hang guard; a full run needs well under two thousand cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One conversion and readout; poke repeats start while busy, which must be ignored.
  task automatic run_word(input sasr_pkg::sasr_mode_t m, input logic [15:0] v, input logic poke);
    int n;
    int w0;
    @(negedge clk);
    mode_sel = m;
    sample = v;
    start = 1'b1;
    falls = 0;
    w0 = words;
    @(negedge clk);
    start = 1'b0;
    if (poke) begin
      repeat (30) @(negedge clk);
      start = 1'b1;
      sample = ~v;
      @(negedge clk);
      start = 1'b0;
    end
    n = 0;
    while (word_valid !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    check("word_out", word_out, v);
    check("wire_bits", wire_sh, v);
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    repeat (4) @(negedge clk);
    check("fall_count", 16'(falls), 16'h0010);
    check("word_count", 16'(words - w0), 16'h0001);
    check("conv_idle", 16'({conv_busy, result_ready}), 16'h0001);
    check("idle_line", 16'(link.dout), (m == sasr_pkg::SASR_CHAIN) ? 16'h0 : 16'h1);
    $display("test run_word mode %0d done", m);
  endtask : run_word

  // Lone converter: both-low drive, select-mode start, conversion length, 4-wire readout.
  task automatic solo_device();
    int n;
    @(negedge clk);
    link2.din = 1'b0;
    repeat (4) @(negedge clk);
    check("solo_low", 16'({link2.dout_oe_n, link2.dout}), 16'h0000);
    link2.din = 1'b1;
    repeat (2) @(negedge clk);
    link2.conversion_start_pin = 1'b1;
    n = 0;
    while (conv_busy2 !== 1'b1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    check("solo_float", 16'(link2.dout_oe_n), 16'h0001);
    n = 0;
    while (conv_busy2 === 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    check("conv_len", 16'(n >= sasr_pkg::TCONV_MIN_CYC && n <= sasr_pkg::TCONV_MAX_CYC),
      16'h0001);
    check("solo_ready", 16'(result_ready2), 16'h0001);
    link2.din = 1'b0;
    repeat (4) @(negedge clk);
    check("solo_msb", 16'({link2.dout_oe_n, link2.dout}), 16'(sample2[15]));
    // One link clock pulse of 40 ns, off the host clock's edges.
    #13 link2.sclk = 1'b1;
    #40 link2.sclk = 1'b0;
    repeat (2) @(negedge clk);
    check("solo_next", 16'({link2.dout_oe_n, link2.dout}), 16'({1'b0, sample2[14]}));
    link2.din = 1'b1;
    repeat (4) @(negedge clk);
    check("solo_deselect", 16'(link2.dout_oe_n), 16'h0001);
    link2.conversion_start_pin = 1'b0;
    // Select pin wired to the start pin: both rise together, so chain mode.
    link2.din = 1'b0;
    repeat (4) @(negedge clk);
    link2.din = 1'b1;
    link2.conversion_start_pin = 1'b1;
    repeat (6) @(negedge clk);
    check("solo_tied", 16'({conv_busy2, link2.dout_oe_n}), 16'h0002);
    $display("test solo_device done");
  endtask : solo_device

  task automatic tally_and_finish();
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  // Full-scale codes in 3-wire mode, the codes either side of zero in 4-wire mode and patterned codes in chain mode, run back to back.
  initial begin
    link2.conversion_start_pin = 1'b0;
    link2.din = 1'b1;
    link2.sclk = 1'b0;
    repeat (12) @(negedge clk);
    reset = 1'b0;
    run_word(sasr_pkg::SASR_3WIRE, 16'h8000, 1'b0);
    run_word(sasr_pkg::SASR_3WIRE, 16'h7fff, 1'b1);
    run_word(sasr_pkg::SASR_4WIRE, 16'h0001, 1'b0);
    run_word(sasr_pkg::SASR_4WIRE, 16'hffff, 1'b1);
    run_word(sasr_pkg::SASR_CHAIN, 16'ha5c3, 1'b0);
    run_word(sasr_pkg::SASR_CHAIN, 16'h3c5a, 1'b0);
    solo_device();
    tally_and_finish();
  end
endmodule : sasr_test

`default_nettype wire
